// ### tb/sgp_gpio_port_tb.sv
`timescale 1ns/1ps
`include "sgp_defs.svh"
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("BAD %0t got %h want %h", $time, g, e); \
        end \
    end

module sgp_gpio_port_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pslverr, pready;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic [5:0]  ext = 6'h00, pen = 6'h00, pval = 6'h00, pin_in, analog_en;
    logic [4:0]  pin_out, pin_oe;
    logic        er;
    int          failures = 0, checks = 0;

    always #4 clk = ~clk;

    sgp_pin_model i_sgp_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_in(pin_in));

    sgp_gpio_port i_sgp_gpio_port (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .ANALOG_EN(analog_en),
        .CMP3_EN(pen[0]), .CMP3_OUT(pval[0]), .SCLK_EN(pen[1]), .SCLK_OUT(pval[1]),
        .TX_EN(pen[2]), .TX_OUT(pval[2]), .SDATA_EN(pen[3]), .SDATA_OUT(pval[3]),
        .CMP4_EN(pen[4]), .CMP4_OUT(pval[4]), .CMP5_EN(pen[5]), .CMP5_OUT(pval[5]));

    // ------------------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------------------
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) begin
            failures++;
            $display("BAD %0t bus timeout", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // An idle edge keeps back-to-back calls from driving psel twice in one time step.
        @(posedge clk);
    endtask : bus

    // Pin outputs are registered behind the registers, so let them land before looking.
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    function automatic logic [4:0] exp_mux(input logic [5:0] e, input logic [5:0] v, input logic [4:0] l);
        logic [4:0] r;
        r[0] = e[0] ? v[0] : l[0];
        r[1] = e[1] ? v[1] : (e[2] ? v[2] : l[1]);
        r[2] = e[3] ? v[3] : l[2];
        r[3] = e[4] ? v[4] : l[3];
        r[4] = e[5] ? v[5] : l[4];
        return r;
    endfunction : exp_mux

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        bus(1'b0, `SGP_OFS_DIR, 32'h0);   `CHK(rd, 32'h3f)
        bus(1'b0, `SGP_OFS_ANSEL, 32'h0); `CHK(rd, 32'h3f)
        `CHK(analog_en, 6'h3f)
        `CHK(pin_oe, 5'h00)
        ext <= 6'h3f;
        settle;
        bus(1'b0, `SGP_OFS_DATA, 32'h0);  `CHK(rd, 32'h0)
    endtask : t_reset

    task automatic t_drive;
        bus(1'b1, `SGP_OFS_ANSEL, 32'h0);
        bus(1'b1, `SGP_OFS_DIR, 32'hff);
        bus(1'b0, `SGP_OFS_DIR, 32'h0); `CHK(rd, 32'h3f)
        bus(1'b1, `SGP_OFS_DIR, 32'h0);
        bus(1'b0, `SGP_OFS_DIR, 32'h0); `CHK(rd, 32'h20)
        ext <= 6'h00;
        bus(1'b1, `SGP_OFS_DATA, 32'hea);
        settle;
        `CHK(pin_oe, 5'h1f)
        `CHK(analog_en, 6'h00)
        `CHK(pin_out, 5'h0a)
        bus(1'b0, `SGP_OFS_DATA, 32'h0); `CHK(rd, 32'h0a)
        ext <= 6'h20;
        settle;
        bus(1'b0, `SGP_OFS_DATA, 32'h0); `CHK(rd, 32'h2a)
    endtask : t_drive

    // A merge write with an analog pin stores that pin as zero, a known trap for software.
    task automatic t_rmw;
        bus(1'b1, `SGP_OFS_DIR, 32'h1f);
        ext <= 6'h15;
        bus(1'b1, `SGP_OFS_ANSEL, 32'h04);
        bus(1'b0, `SGP_OFS_ANSEL, 32'h0); `CHK(rd, 32'h04)
        pstrb <= 4'h0;
        bus(1'b1, `SGP_OFS_DATA, 32'h0);
        pstrb <= 4'hf;
        bus(1'b0, `SGP_OFS_LATCH, 32'h0); `CHK(rd, 32'h11)
    endtask : t_rmw

    task automatic t_analog;
        bus(1'b1, `SGP_OFS_ANSEL, 32'h3f);
        bus(1'b1, `SGP_OFS_DIR, 32'h0);
        bus(1'b1, `SGP_OFS_LATCH, 32'h15);
        settle;
        `CHK(pin_oe, 5'h1f)
        `CHK(pin_out, 5'h15)
        bus(1'b0, `SGP_OFS_DATA, 32'h0); `CHK(rd, 32'h0)
        bus(1'b1, `SGP_OFS_DIR, 32'h1f);
        settle;
        `CHK(pin_oe, 5'h00)
    endtask : t_analog

    task automatic t_prio;
        logic [4:0] lat;
        bus(1'b1, `SGP_OFS_DIR, 32'h0);
        pval <= 6'h3d;
        for (int j = 0; j < 2; j++) begin
            lat = (j == 0) ? 5'h0a : 5'h15;
            bus(1'b1, `SGP_OFS_LATCH, {27'h0, lat});
            for (int i = 0; i < 64; i++) begin
                pen <= i[5:0];
                settle;
                `CHK(pin_out, exp_mux(pen, pval, lat))
            end
        end
        pen <= 6'h00;
    endtask : t_prio

    task automatic t_bad;
        bus(1'b0, 12'h010, 32'h0); `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        bus(1'b1, 12'h010, 32'h1f);
        bus(1'b0, `SGP_OFS_DIR, 32'h0); `CHK(rd, 32'h20)
        `CHK(er, 1'b0)
    endtask : t_bad

    task automatic t_rerst;
        bus(1'b1, `SGP_OFS_ANSEL, 32'h0);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(analog_en, 6'h3f)
        `CHK(pin_oe, 5'h00)
        bus(1'b0, `SGP_OFS_DIR, 32'h0); `CHK(rd, 32'h3f)
    endtask : t_rerst

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_drive;
        t_rmw;
        t_analog;
        t_prio;
        t_bad;
        t_rerst;
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop;
    end
endmodule : sgp_gpio_port_tb

// ### tb/sgp_pin_model.sv
`timescale 1ns/1ps

module sgp_pin_model (
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    input  wire logic [5:0] ext_lvl,
    output logic      [5:0] pin_in
);
    // A driven pin shows the port's own value; the outside level only reaches an undriven pin.
    // Pin 5 has no driver, so it always shows the outside level.
    always_comb begin
        pin_in[5]   = ext_lvl[5];
        pin_in[4:0] = (pin_out & pin_oe) | (ext_lvl[4:0] & ~pin_oe);
    end
endmodule : sgp_pin_model

// ### verilog/sgp_defs.svh
`ifndef SGP_DEFS_SVH
`define SGP_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------------------
`define SGP_OFS_DATA      12'h000
`define SGP_OFS_DIR       12'h004
`define SGP_OFS_ANSEL     12'h008
`define SGP_OFS_LATCH     12'h00c
`define SGP_ADDR_W        12
`define SGP_NPINS         6
`define SGP_NOUT          5
`define SGP_DIR_RST       5'h1f
`define SGP_ANSEL_RST     6'h3f
`define SGP_LATCH_RST     5'h00

`endif

// ### verilog/sgp_gpio_port.sv
`timescale 1ns/1ps
`include "sgp_defs.svh"

module sgp_gpio_port (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [5:0]  PIN_IN,
    output logic      [4:0]  PIN_OUT,
    output logic      [4:0]  PIN_OE,
    output logic      [5:0]  ANALOG_EN,
    input  wire logic        CMP3_EN,
    input  wire logic        CMP3_OUT,
    input  wire logic        SCLK_EN,
    input  wire logic        SCLK_OUT,
    input  wire logic        TX_EN,
    input  wire logic        TX_OUT,
    input  wire logic        SDATA_EN,
    input  wire logic        SDATA_OUT,
    input  wire logic        CMP4_EN,
    input  wire logic        CMP4_OUT,
    input  wire logic        CMP5_EN,
    input  wire logic        CMP5_OUT
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [4:0]            dir;
    logic [5:0]            ansel;
    logic [4:0]            latch;
    logic [5:0]            pin_sample;
    logic [4:0]            next_pin_val;
    logic [4:0]            next_latch;
    logic [31:0]           next_rdata;
    logic                  setup;
    logic                  wr_fire;
    sgp_pkg::sgp_reg_type  sel;

    function automatic sgp_pkg::sgp_reg_type decode(input logic [11:0] addr);
        unique case (addr)
            `SGP_OFS_DATA:  decode = sgp_pkg::SGP_REG_DATA;
            `SGP_OFS_DIR:   decode = sgp_pkg::SGP_REG_DIR;
            `SGP_OFS_ANSEL: decode = sgp_pkg::SGP_REG_ANSEL;
            `SGP_OFS_LATCH: decode = sgp_pkg::SGP_REG_LATCH;
            default:        decode = sgp_pkg::SGP_REG_NONE;
        endcase
    endfunction : decode

    assign sel     = decode(PADDR);
    assign setup   = PSEL && !PENABLE;
    assign wr_fire = PSEL && PENABLE && PREADY && PWRITE;

    // ------------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------------
    // Pins are taken as synchronous; one sample stage gives a stable image for
    // reads and for the read-modify-write merge.
    always_ff @(posedge CLK) begin
        if (RST) begin
            pin_sample <= 6'h00;
        end else begin
            pin_sample <= PIN_IN;
        end
    end

    // ------------------------------------------------------------------------
    // APB slave: one wait-free access phase, answer registered
    // ------------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (sel)
            sgp_pkg::SGP_REG_DATA:  next_rdata[5:0] = pin_sample & ~ansel;
            sgp_pkg::SGP_REG_DIR:   next_rdata[5:0] = {1'b1, dir};
            sgp_pkg::SGP_REG_ANSEL: next_rdata[5:0] = ansel;
            sgp_pkg::SGP_REG_LATCH: next_rdata[4:0] = latch;
            sgp_pkg::SGP_REG_NONE:  next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup && (sel == sgp_pkg::SGP_REG_NONE);
            if (setup && !PWRITE) begin
                PRDATA <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // A data write merges the sampled pin levels into the lanes not written.
    // With analog pins this reads zero, which software must expect.
    always_comb begin
        next_latch = latch;
        if (sel == sgp_pkg::SGP_REG_DATA) begin
            next_latch = PSTRB[0] ? PWDATA[4:0] : (pin_sample[4:0] & ~ansel[4:0]);
        end else if (sel == sgp_pkg::SGP_REG_LATCH && PSTRB[0]) begin
            next_latch = PWDATA[4:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            latch <= `SGP_LATCH_RST;
        end else if (wr_fire) begin
            latch <= next_latch;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            dir <= `SGP_DIR_RST;
        end else if (wr_fire && sel == sgp_pkg::SGP_REG_DIR && PSTRB[0]) begin
            dir <= PWDATA[4:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ansel <= `SGP_ANSEL_RST;
        end else if (wr_fire && sel == sgp_pkg::SGP_REG_ANSEL && PSTRB[0]) begin
            ansel <= PWDATA[5:0];
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    sgp_out_mux u_mux (
        .latch     (latch),
        .cmp3_en   (CMP3_EN),
        .cmp3_val  (CMP3_OUT),
        .sclk_en   (SCLK_EN),
        .sclk_val  (SCLK_OUT),
        .tx_en     (TX_EN),
        .tx_val    (TX_OUT),
        .sdata_en  (SDATA_EN),
        .sdata_val (SDATA_OUT),
        .cmp4_en   (CMP4_EN),
        .cmp4_val  (CMP4_OUT),
        .cmp5_en   (CMP5_EN),
        .cmp5_val  (CMP5_OUT),
        .pin_val   (next_pin_val)
    );

    // Pin 5 has no driver at all, so it can never be driven.
    always_ff @(posedge CLK) begin
        if (RST) begin
            PIN_OE    <= 5'h00;
            PIN_OUT   <= 5'h00;
            ANALOG_EN <= `SGP_ANSEL_RST;
        end else begin
            PIN_OE    <= ~dir;
            PIN_OUT   <= next_pin_val;
            ANALOG_EN <= ansel;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_oe_dir;
        @(posedge CLK) disable iff (RST)
        ##1 PIN_OE == ~$past(dir);
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("driver enable not following direction");

    property p_drive_latch;
        @(posedge CLK) disable iff (RST)
        (!CMP4_EN && !dir[3]) |=> (PIN_OE[3] && PIN_OUT[3] == $past(latch[3]));
    endproperty
    a_drive_latch: assert property (p_drive_latch) else $error("output pin not driven from latch");

    property p_upper_zero;
        @(posedge CLK) disable iff (RST)
        (setup && !PWRITE && sel == sgp_pkg::SGP_REG_DATA) |=> PREADY && PRDATA[31:6] == 26'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("data upper bits not zero");

    property p_dir_bit5;
        @(posedge CLK) disable iff (RST)
        (setup && !PWRITE && sel == sgp_pkg::SGP_REG_DIR) |=> PRDATA[7:5] == 3'b001;
    endproperty
    a_dir_bit5: assert property (p_dir_bit5) else $error("direction bit 5 not one");

    property p_analog_zero;
        @(posedge CLK) disable iff (RST)
        (setup && !PWRITE && sel == sgp_pkg::SGP_REG_DATA) |=>
            (PRDATA[5:0] & $past(ansel)) == 6'h00;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_rmw_merge;
        @(posedge CLK) disable iff (RST)
        (wr_fire && sel == sgp_pkg::SGP_REG_DATA && !PSTRB[0]) |=>
            latch == ($past(pin_sample[4:0]) & ~$past(ansel[4:0]));
    endproperty
    a_rmw_merge: assert property (p_rmw_merge) else $error("read-modify-write merge wrong");

    property p_reset_vals;
        @(posedge CLK)
        $past(RST) |-> (ansel == `SGP_ANSEL_RST && dir == `SGP_DIR_RST);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_prio_p1;
        @(posedge CLK) disable iff (RST)
        (SCLK_EN && TX_EN) |=> PIN_OUT[1] == $past(SCLK_OUT);
    endproperty
    a_prio_p1: assert property (p_prio_p1) else $error("pin 1 priority wrong");

    property p_analog_drive;
        @(posedge CLK) disable iff (RST)
        (CMP3_EN && ansel[0]) |=> PIN_OUT[0] == $past(CMP3_OUT);
    endproperty
    a_analog_drive: assert property (p_analog_drive) else $error("analog pin lost output function");

    property p_ready_one;
        @(posedge CLK) disable iff (RST)
        setup |=> PREADY ##1 !PREADY;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready not a single cycle");

    // ------------------------------------------------------------------------
    // Register and priority checks
    // ------------------------------------------------------------------------
    // These pin down each register on its own; dir's hold check covers writes to other registers, latch's only cycles with no write and ansel has none,
    // so a decode slip that lands a write in dir shows up at the edge where it happens, but a slip into ansel or latch does not.
    property p_dir_write;
        @(posedge CLK) disable iff (RST)
        (wr_fire && sel == sgp_pkg::SGP_REG_DIR && PSTRB[0]) |=> dir == $past(PWDATA[4:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_dir_hold;
        @(posedge CLK) disable iff (RST)
        !(wr_fire && sel == sgp_pkg::SGP_REG_DIR) |=> $stable(dir);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed without a write");

    property p_dir_read;
        @(posedge CLK) disable iff (RST)
        (setup && !PWRITE && sel == sgp_pkg::SGP_REG_DIR) |=>
            PRDATA[31:6] == 26'h0 && PRDATA[4:0] == $past(dir);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read wrong");

    property p_ansel_write;
        @(posedge CLK) disable iff (RST)
        (wr_fire && sel == sgp_pkg::SGP_REG_ANSEL && PSTRB[0]) |=> ansel == $past(PWDATA[5:0]);
    endproperty
    a_ansel_write: assert property (p_ansel_write) else $error("analog select write lost");

    property p_ansel_read;
        @(posedge CLK) disable iff (RST)
        (setup && !PWRITE && sel == sgp_pkg::SGP_REG_ANSEL) |=> PRDATA == {26'h0, $past(ansel)};
    endproperty
    a_ansel_read: assert property (p_ansel_read) else $error("analog select read wrong");

    property p_analog_copy;
        @(posedge CLK) disable iff (RST)
        1'b1 |=> ANALOG_EN == $past(ansel);
    endproperty
    a_analog_copy: assert property (p_analog_copy) else $error("analog enable not following select");

    property p_data_write;
        @(posedge CLK) disable iff (RST)
        (wr_fire && sel == sgp_pkg::SGP_REG_DATA && PSTRB[0]) |=> latch == $past(PWDATA[4:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write did not reach latch");

    property p_latch_hold;
        @(posedge CLK) disable iff (RST)
        !wr_fire |=> $stable(latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without a write");

    property p_data_pins;
        @(posedge CLK) disable iff (RST)
        (setup && !PWRITE && sel == sgp_pkg::SGP_REG_DATA && ansel == 6'h00) |=>
            PRDATA[5:0] == $past(pin_sample);
    endproperty
    a_data_pins: assert property (p_data_pins) else $error("digital pin read wrong");

    property p_rdata_hold;
        @(posedge CLK) disable iff (RST)
        !(setup && !PWRITE) |=> $stable(PRDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

    // Direction alone gates the drivers; analog mode must not drop them.
    property p_oe_analog;
        @(posedge CLK) disable iff (RST)
        (ansel[0] && !dir[0]) |=> PIN_OE[0];
    endproperty
    a_oe_analog: assert property (p_oe_analog) else $error("analog mode turned a driver off");

    property p_analog_out;
        @(posedge CLK) disable iff (RST)
        (!CMP3_EN && ansel[0] && !dir[0]) |=> PIN_OE[0] && PIN_OUT[0] == $past(latch[0]);
    endproperty
    a_analog_out: assert property (p_analog_out) else $error("analog pin lost its latch drive");

    // The peripheral enables pick the value only; the driver enable stays with direction.
    property p_prio_p0;
        @(posedge CLK) disable iff (RST)
        !CMP3_EN |=> PIN_OUT[0] == $past(latch[0]);
    endproperty
    a_prio_p0: assert property (p_prio_p0) else $error("pin 0 not from latch");

    property p_prio_tx;
        @(posedge CLK) disable iff (RST)
        (!SCLK_EN && TX_EN) |=> PIN_OUT[1] == $past(TX_OUT);
    endproperty
    a_prio_tx: assert property (p_prio_tx) else $error("pin 1 transmit priority wrong");

    property p_prio_p2;
        @(posedge CLK) disable iff (RST)
        SDATA_EN |=> PIN_OUT[2] == $past(SDATA_OUT);
    endproperty
    a_prio_p2: assert property (p_prio_p2) else $error("pin 2 priority wrong");

    property p_prio_p3;
        @(posedge CLK) disable iff (RST)
        CMP4_EN |=> PIN_OUT[3] == $past(CMP4_OUT);
    endproperty
    a_prio_p3: assert property (p_prio_p3) else $error("pin 3 priority wrong");

    property p_prio_p4;
        @(posedge CLK) disable iff (RST)
        CMP5_EN |=> PIN_OUT[4] == $past(CMP5_OUT);
    endproperty
    a_prio_p4: assert property (p_prio_p4) else $error("pin 4 priority wrong");

endmodule : sgp_gpio_port

// ### verilog/sgp_out_mux.sv
`timescale 1ns/1ps
`include "sgp_defs.svh"

module sgp_out_mux (
    input  wire logic [4:0] latch,
    input  wire logic       cmp3_en,
    input  wire logic       cmp3_val,
    input  wire logic       sclk_en,
    input  wire logic       sclk_val,
    input  wire logic       tx_en,
    input  wire logic       tx_val,
    input  wire logic       sdata_en,
    input  wire logic       sdata_val,
    input  wire logic       cmp4_en,
    input  wire logic       cmp4_val,
    input  wire logic       cmp5_en,
    input  wire logic       cmp5_val,
    output logic      [4:0] pin_val
);

    // ------------------------------------------------------------------------
    // Fixed output priority, highest first, latch last
    // ------------------------------------------------------------------------
    // Analog select is deliberately not an input here, so analog pins keep
    // their digital drivers.
    always_comb begin
        pin_val[0] = cmp3_en ? cmp3_val : latch[0];
        if (sclk_en) begin
            pin_val[1] = sclk_val;
        end else if (tx_en) begin
            pin_val[1] = tx_val;
        end else begin
            pin_val[1] = latch[1];
        end
        pin_val[2] = sdata_en ? sdata_val : latch[2];
        pin_val[3] = cmp4_en ? cmp4_val : latch[3];
        pin_val[4] = cmp5_en ? cmp5_val : latch[4];
    end

endmodule : sgp_out_mux

// ### verilog/sgp_pkg.sv
package sgp_pkg;

    typedef enum logic [2:0] {
        SGP_REG_DATA,
        SGP_REG_DIR,
        SGP_REG_ANSEL,
        SGP_REG_LATCH,
        SGP_REG_NONE
    } sgp_reg_type;

endpackage : sgp_pkg
